// ### src/def_error_flags.sv
/*
 * Error flags of the low debug status register: overrun, no-response
 * and read-invalid, with access suppression, substitute data and
 * long-acknowledge requests.
 * Assumes the command decoder and link engine run on ref_clk and
 * deliver one-cycle event pulses; the debug pin is raw and is
 * synchronised here.
 */
`timescale 1ns/1ns

// Contract
// - Set overrun when a new command starts before the current one completes.
// - With ack on, host pulling the pin low during pending ack sets overrun.
// - While overrun is set, suppress all internal accesses requested by commands.
// - Only a synchronization pulse clears overrun; host must send one to recover.
// - Register writes never change the overrun flag.
// - Ack on, immediate off: no free cycle in 512 core clocks sets no-response.
// - Ack off or immediate: unfinished access at read-out or next command sets no-response; code checks next command for writes only.
// - Memory or PC-sample access in stop with continue-select clear sets no-response.
// - On those no-response cases abort the access, unless external wait holds it.
// - Debug-mode entry during wait sets no-response, not aborted, completes after wait.
// - Each CPU register access in wait sets no-response again if cleared.
// - A command arriving while returning from wait sets no-response.
// - Single step issued as device enters wait sets no-response, regardless of mode; code sets it only with debug_enabled high.
// - With no-response set, every data byte of that access reads 0xEE.
// - Writing one clears no-response or read-invalid; writing zero leaves them.
// - ECC error on a debug read sets read-invalid; real data still returned.
// - Ack on: acked command setting flags [3:1] gets a long acknowledge.
// - After pin-low overrun, delay long ack until a byte arrives, then keep long.
module def_error_flags
    import def_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic debug_pin,
    input wire logic ack_enable,
    input wire logic steal_enable,
    input wire logic ack_pending,
    input wire logic sync_pulse,
    input wire logic cmd_start,
    input wire logic cmd_busy,
    input wire logic cmd_with_ack,
    input wire logic cmd_end,
    input wire logic byte_received,
    input wire logic access_req,
    input wire logic access_is_write,
    input wire logic access_is_memory,
    input wire logic sample_program_counter_cmd,
    input wire logic access_done,
    input wire logic free_cycle,
    input wire logic readout_start,
    input wire logic external_wait_request,
    input wire logic stop_mode,
    input wire logic stop_continue_select,
    input wire logic wait_mode,
    input wire logic wait_returning,
    input wire logic wait_entering,
    input wire logic enter_debug_cmd,
    input wire logic cpu_reg_cmd,
    input wire logic single_step_cmd,
    input wire logic debug_enabled,
    input wire logic illegal_access_set,
    input wire logic ecc_error,
    input wire logic [7:0] read_data_in,
    input wire logic status_write,
    input wire logic [7:0] status_write_data,
    output logic [7:0] debug_status_low_reg,
    output logic overrun_flag,
    output logic no_response_flag,
    output logic read_invalid_flag,
    output logic access_grant,
    output logic access_abort,
    output logic debug_entry_deferred,
    output logic [7:0] read_data_out,
    output logic long_ack
);
    typedef struct packed {
        logic pin_meta;
        logic pin_sync;
        logic pin_prev;
        logic overrun;
        logic no_response;
        logic read_invalid;
        logic acc_active;
        logic acc_write;
        logic write_pending;
        logic abort_pend;
        logic abort;
        logic entry_deferred;
        logic pin_overrun_hold;
        logic long_sticky;
        logic err_in_cmd;
        logic long_ack;
        logic [7:0] rdata;
    } def_flags_state_type;

    def_flags_state_type state;
    def_flags_state_type next_state;
    logic timeout_run;
    logic timeout_hit;

    // Timer only runs for acknowledged, non-immediate accesses waiting a free cycle
    assign timeout_run = state.acc_active && ack_enable && !steal_enable && !free_cycle;

    def_timeout u_timeout (
        .ref_clk(ref_clk),
        .rst(rst),
        .run(timeout_run),
        .expired(timeout_hit)
    );

    logic pin_fall;
    logic stop_block;
    logic late_access;
    logic abortable_fail;
    logic wait_fail;
    logic nr_set;
    logic ri_set;

    always_comb begin
        next_state = state;
        next_state.pin_meta = debug_pin;
        next_state.pin_sync = state.pin_meta;
        next_state.pin_prev = state.pin_sync;
        next_state.abort = 1'b0;
        next_state.long_ack = 1'b0;
        pin_fall = state.pin_prev && !state.pin_sync;

        stop_block = access_req && stop_mode && !stop_continue_select
            && (access_is_memory || sample_program_counter_cmd);
        late_access = (!ack_enable || steal_enable)
            && ((state.acc_active && readout_start)
            || (state.write_pending && cmd_start));
        abortable_fail = (timeout_hit && state.acc_active) || late_access || stop_block;
        wait_fail = (enter_debug_cmd && wait_mode)
            || (cpu_reg_cmd && wait_mode)
            || (cmd_start && wait_returning)
            || (single_step_cmd && debug_enabled && wait_entering);
        nr_set = abortable_fail || wait_fail;
        ri_set = access_done && state.acc_active && !state.acc_write && ecc_error;

        // Access tracking; no new access starts while an overrun stands
        if (access_req && !state.overrun && !stop_block) begin
            next_state.acc_active = 1'b1;
            next_state.acc_write = access_is_write;
            next_state.write_pending = access_is_write;
        end
        if (access_done) begin
            next_state.acc_active = 1'b0;
            next_state.write_pending = 1'b0;
            next_state.rdata = (state.no_response || nr_set) ? DEF_SUBST_BYTE : read_data_in;
        end else if (state.no_response) begin
            next_state.rdata = DEF_SUBST_BYTE;
        end

        // External wait holds the abort back until it is released
        if (abortable_fail && state.acc_active) begin
            next_state.abort_pend = 1'b1;
        end
        if ((next_state.abort_pend || state.abort_pend) && !external_wait_request) begin
            next_state.abort = 1'b1;
            next_state.abort_pend = 1'b0;
            next_state.acc_active = 1'b0;
            next_state.write_pending = 1'b0;
        end

        if (enter_debug_cmd && wait_mode) begin
            next_state.entry_deferred = 1'b1;
        end else if (!wait_mode) begin
            next_state.entry_deferred = 1'b0;
        end

        // Clear first so a same-cycle set wins
        if (status_write && status_write_data[DEF_BIT_NO_RESPONSE]) begin
            next_state.no_response = 1'b0;
        end
        if (status_write && status_write_data[DEF_BIT_READ_INVALID]) begin
            next_state.read_invalid = 1'b0;
        end
        // Overrun ignores status writes entirely
        if (sync_pulse) begin
            next_state.overrun = 1'b0;
            next_state.pin_overrun_hold = 1'b0;
            next_state.long_sticky = 1'b0;
        end
        if (cmd_start && cmd_busy) begin
            next_state.overrun = 1'b1;
        end
        if (ack_enable && ack_pending && pin_fall) begin
            next_state.overrun = 1'b1;
            next_state.pin_overrun_hold = 1'b1;
        end
        if (nr_set) begin
            next_state.no_response = 1'b1;
        end
        if (ri_set) begin
            next_state.read_invalid = 1'b1;
        end

        // Long ack held off until a full byte follows the offending edge
        if (state.pin_overrun_hold && byte_received) begin
            next_state.pin_overrun_hold = 1'b0;
            next_state.long_sticky = 1'b1;
        end
        // A no-response, read-invalid or illegal-access flag raised any time during the command makes its acknowledge long
        if (cmd_start) begin
            next_state.err_in_cmd = 1'b0;
        end
        if (nr_set || ri_set || illegal_access_set) begin
            next_state.err_in_cmd = 1'b1;
        end
        if (cmd_end) begin
            next_state.err_in_cmd = 1'b0;
        end
        if (cmd_end && cmd_with_ack && ack_enable && !state.pin_overrun_hold) begin
            next_state.long_ack = nr_set || ri_set || illegal_access_set || state.err_in_cmd
                || state.long_sticky;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state <= '0;
            state.pin_meta <= 1'b1;
            state.pin_sync <= 1'b1;
            state.pin_prev <= 1'b1;
        end else begin
            state <= next_state;
        end
    end

    always_comb begin
        debug_status_low_reg = DEF_STATUS_RESET;
        debug_status_low_reg[DEF_BIT_OVERRUN] = state.overrun;
        debug_status_low_reg[DEF_BIT_NO_RESPONSE] = state.no_response;
        debug_status_low_reg[DEF_BIT_READ_INVALID] = state.read_invalid;
    end

    assign overrun_flag = state.overrun;
    assign no_response_flag = state.no_response;
    assign read_invalid_flag = state.read_invalid;
    assign access_grant = access_req && !state.overrun && !stop_block;
    assign access_abort = state.abort;
    assign debug_entry_deferred = state.entry_deferred;
    assign read_data_out = state.rdata;
    assign long_ack = state.long_ack;
endmodule

// ### src/def_pkg.sv
/*
 * Package for the debug error flag logic: register field positions,
 * reset values, substitute data and timing counts.
 * Assumes a single core clock at 50 MHz.
 */
package def_pkg;
    localparam int unsigned DEF_CORE_HZ = 50000000;
    localparam int DEF_BIT_OVERRUN = 4;
    localparam int DEF_BIT_NO_RESPONSE = 3;
    localparam int DEF_BIT_READ_INVALID = 2;
    localparam logic [7:0] DEF_STATUS_RESET = 8'h00;
    localparam logic [7:0] DEF_SUBST_BYTE = 8'hee;
    localparam logic [9:0] DEF_FREE_CYCLE_TIMEOUT = 10'h200;
    localparam logic [2:0] DEF_BYTE_BITS = 3'h7;
endpackage

// ### src/def_timeout.sv
/*
 * Free-cycle wait counter for debug accesses.
 * Assumes run comes from logic on the same clock.
 */
`timescale 1ns/1ns
module def_timeout
    import def_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic run,
    output logic expired
);
    typedef struct packed {
        logic [9:0] count;
        logic expired;
    } def_timeout_state_type;

    def_timeout_state_type state;
    def_timeout_state_type next_state;

    always_comb begin
        next_state = state;
        next_state.expired = 1'b0;
        if (!run) begin
            next_state.count = 10'h000;
        end else if (state.count == DEF_FREE_CYCLE_TIMEOUT - 10'h001) begin
            next_state.expired = 1'b1;
            next_state.count = 10'h000;
        end else begin
            next_state.count = state.count + 10'h001;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign expired = state.expired;
endmodule

// ### tb/def_chk.sv
/* Assertion checker for the debug error flags, bound to def_error_flags.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ns
module def_chk
    import def_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic cmd_start,
    input wire logic cmd_busy,
    input wire logic cmd_end,
    input wire logic sync_pulse,
    input wire logic long_ack,
    input wire logic overrun_flag,
    input wire logic no_response_flag,
    input wire logic read_invalid_flag,
    input wire logic access_grant,
    input wire logic access_abort,
    input wire logic access_req,
    input wire logic access_done,
    input wire logic ecc_error,
    input wire logic status_write,
    input wire logic external_wait_request,
    input wire logic stop_mode,
    input wire logic stop_continue_select,
    input wire logic access_is_memory,
    input wire logic sample_program_counter_cmd,
    input wire logic [7:0] read_data_in,
    input wire logic [7:0] read_data_out,
    input wire logic [7:0] status_write_data,
    input wire logic [7:0] debug_status_low_reg
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    AST_OVR_SET: assert property (cmd_start && cmd_busy |=> overrun_flag)
        else $error("overrun not set on early command");
    AST_NO_GRANT: assert property (overrun_flag |-> !access_grant)
        else $error("access granted during overrun");
    AST_OVR_FALL: assert property ($fell(overrun_flag) |-> $past(sync_pulse) || $past(rst))
        else $error("overrun cleared without sync");
    AST_OVR_KEEP: assert property (overrun_flag && !sync_pulse |=> overrun_flag)
        else $error("overrun dropped");
    AST_STOP_BLOCK: assert property (access_req && stop_mode && !stop_continue_select
        && (access_is_memory || sample_program_counter_cmd) |-> !access_grant ##1 no_response_flag)
        else $error("stop access not refused");
    AST_ABORT_HOLD: assert property (access_abort |-> !$past(external_wait_request))
        else $error("abort while external wait held");
    AST_SUBST: assert property (no_response_flag && access_done |=> read_data_out == DEF_SUBST_BYTE)
        else $error("substitute byte missing");
    AST_READ_INVALID_FLAG_KEEP: assert property (read_invalid_flag
        && !(status_write && status_write_data[DEF_BIT_READ_INVALID])
        |=> read_invalid_flag)
        else $error("read-invalid lost without clear");
    AST_READ_INVALID_FLAG_SET: assert property (access_done && ecc_error && !no_response_flag
        |=> read_invalid_flag && read_data_out == $past(read_data_in))
        else $error("ecc read not flagged or data altered");
    AST_LONG_ACK: assert property (long_ack |-> $past(cmd_end))
        else $error("long ack without command end");
    AST_MAP: assert property (debug_status_low_reg == {3'h0, overrun_flag, no_response_flag,
        read_invalid_flag, 2'h0})
        else $error("status byte does not match flags");
    AST_RESET: assert property (disable iff (1'b0) rst |=> debug_status_low_reg == 8'h00)
        else $error("flags survive reset");
endmodule
bind def_error_flags def_chk i_def_chk (.*);

// ### tb/def_host.sv
/* Behavioural debug host on the single-wire pin.
   Assumes its tasks are called at falling clock edges. */
`timescale 1ns/1ns
module def_host (
    input wire logic ref_clk,
    output logic debug_pin,
    output logic sync_pulse
);
    // Pin has a pull-up, so released means high
    initial begin
        debug_pin = 1'b1;
        sync_pulse = 1'b0;
    end
    // Misbehaviour on request only: pin low while an acknowledge is pending
    task pull_low(input int n);
        debug_pin = 1'b0;
        repeat (n) @(negedge ref_clk);
        debug_pin = 1'b1;
    endtask
    task send_sync;
        sync_pulse = 1'b1;
        @(negedge ref_clk);
        sync_pulse = 1'b0;
    endtask
endmodule

// ### tb/def_error_flags_tb.sv
/* Testbench for the debug error flags with a behavioural host.
   Assumes the checker is bound in separately. */
`timescale 1ns/1ns
module def_error_flags_tb
    import def_pkg::*;
;
    logic ref_clk = '0, rst = '1, debug_pin, sync_pulse, ack_enable = '0, steal_enable = '0, ack_pending = '0;
    logic cmd_start = '0, cmd_busy = '0, cmd_with_ack = '0, cmd_end = '0, byte_received = '0, access_req = '0;
    logic access_is_write = '0, access_is_memory = '0, sample_program_counter_cmd = '0, access_done = '0;
    logic free_cycle = '0, readout_start = '0, external_wait_request = '0, stop_mode = '0, wait_mode = '0;
    logic stop_continue_select = '0, wait_returning = '0, wait_entering = '0, enter_debug_cmd = '0;
    logic cpu_reg_cmd = '0, single_step_cmd = '0, debug_enabled = '0, illegal_access_set = '0, ecc_error = '0;
    logic status_write = '0, overrun_flag, no_response_flag, read_invalid_flag, access_grant;
    logic access_abort, debug_entry_deferred, long_ack;
    logic [7:0] read_data_in = '0, status_write_data = '0, debug_status_low_reg, read_data_out;
    int bad_count = 0, n_compared = 0;
    def_error_flags i_def_error_flags (.*);
    def_host i_def_host (.ref_clk(ref_clk), .debug_pin(debug_pin), .sync_pulse(sync_pulse));
    initial begin
        forever #10 ref_clk = ~ref_clk;
    end
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge ref_clk);
        s = 1'b0;
    endtask
    task finish_test;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task t_overrun;
        cmd_busy = 1'b1;
        pulse(cmd_start);
        chk(debug_status_low_reg, 8'h10);
        status_write_data = 8'hff;
        pulse(status_write);
        chk(overrun_flag, 1'b1);
        access_req = 1'b1;
        #1 chk(access_grant, 1'b0);
        @(negedge ref_clk);
        access_req = 1'b0;
        cmd_busy = 1'b0;
        i_def_host.send_sync();
        chk(overrun_flag, 1'b0);
        $display("test overrun done");
    endtask
    task t_pin;
        int i;
        ack_enable = 1'b1;
        ack_pending = 1'b1;
        i_def_host.pull_low(2);
        for (i = 0; i < 8 && overrun_flag !== 1'b1; i++) @(negedge ref_clk);
        if (i == 8) begin
            bad_count++;
            finish_test();
        end
        chk(overrun_flag, 1'b1);
        ack_pending = 1'b0;
        i_def_host.send_sync();
        chk(overrun_flag, 1'b0);
        $display("test pin low done");
    endtask
    task t_timeout;
        int n;
        cmd_with_ack = 1'b1;
        pulse(access_req);
        for (n = 0; n < 600 && no_response_flag !== 1'b1; n++) @(negedge ref_clk);
        if (n == 600) begin
            bad_count++;
            finish_test();
        end
        chk(n >= 510 && n <= 514, 1'b1);
        chk(access_abort, 1'b1);
        pulse(cmd_end);
        chk(long_ack, 1'b1);
        read_data_in = 8'h5a;
        pulse(access_done);
        chk(read_data_out, DEF_SUBST_BYTE);
        status_write_data = 8'h00;
        pulse(status_write);
        chk(no_response_flag, 1'b1);
        status_write_data = 8'h08;
        pulse(status_write);
        chk(no_response_flag, 1'b0);
        $display("test timeout done");
    endtask
    task t_ecc;
        free_cycle = 1'b1;
        read_data_in = 8'h3c;
        ecc_error = 1'b1;
        pulse(access_req);
        pulse(access_done);
        ecc_error = 1'b0;
        chk(read_invalid_flag, 1'b1);
        chk(read_data_out, 8'h3c);
        status_write_data = 8'h04;
        pulse(status_write);
        chk(debug_status_low_reg, 8'h00);
        $display("test ecc done");
    endtask
    task t_stop;
        stop_mode = 1'b1;
        access_is_memory = 1'b1;
        access_req = 1'b1;
        #1 chk(access_grant, 1'b0);
        @(negedge ref_clk);
        access_req = 1'b0;
        stop_mode = 1'b0;
        chk(no_response_flag, 1'b1);
        $display("test stop done");
    endtask
    task t_wait;
        status_write_data = 8'h08;
        pulse(status_write);
        wait_mode = 1'b1;
        pulse(enter_debug_cmd);
        chk(no_response_flag, 1'b1);
        chk(debug_entry_deferred, 1'b1);
        pulse(status_write);
        chk(debug_status_low_reg, 8'h00);
        pulse(cpu_reg_cmd);
        chk(no_response_flag, 1'b1);
        wait_mode = 1'b0;
        @(negedge ref_clk);
        chk(debug_entry_deferred, 1'b0);
        pulse(status_write);
        chk(debug_status_low_reg, 8'h00);
        wait_returning = 1'b1;
        pulse(cmd_start);
        wait_returning = 1'b0;
        chk(no_response_flag, 1'b1);
        pulse(status_write);
        chk(debug_status_low_reg, 8'h00);
        debug_enabled = 1'b1;
        wait_entering = 1'b1;
        pulse(single_step_cmd);
        wait_entering = 1'b0;
        chk(no_response_flag, 1'b1);
        $display("test wait done");
    endtask
    task t_late;
        status_write_data = 8'h08;
        pulse(status_write);
        chk(debug_status_low_reg, 8'h00);
        steal_enable = 1'b1;
        access_is_memory = 1'b0;
        access_is_write = 1'b1;
        pulse(access_req);
        pulse(cmd_start);
        access_is_write = 1'b0;
        chk(no_response_flag, 1'b1);
        chk(access_abort, 1'b1);
        $display("test late access done");
    endtask
    task t_resync;
        int i;
        ack_pending = 1'b1;
        i_def_host.pull_low(1);
        for (i = 0; i < 8 && overrun_flag !== 1'b1; i++) @(negedge ref_clk);
        if (i == 8) begin
            bad_count++;
            finish_test();
        end
        ack_pending = 1'b0;
        pulse(cmd_end);
        chk(long_ack, 1'b0);
        pulse(byte_received);
        pulse(cmd_end);
        chk(long_ack, 1'b1);
        i_def_host.send_sync();
        pulse(cmd_end);
        chk(long_ack, 1'b0);
        $display("test resync done");
    endtask
    initial begin
        repeat (2) @(negedge ref_clk);
        rst = 1'b0;
        chk(debug_status_low_reg, DEF_STATUS_RESET);
        t_overrun();
        t_pin();
        t_timeout();
        t_ecc();
        t_stop();
        t_wait();
        t_late();
        t_resync();
        finish_test();
    end
endmodule
